// ---- common/i2c_ctrl_regs.svh ----
// Register offsets, field positions and reset values of the control layer
`ifndef I2C_CTRL_REGS_SVH
`define I2C_CTRL_REGS_SVH

`define OFS_OWN_ADDR   8'h00
`define OFS_INT_MASK   8'h04
`define OFS_INT_FLAGS  8'h08
`define OFS_SCL_LOW    8'h0c
`define OFS_SCL_HIGH   8'h10
`define OFS_BYTE_CNT   8'h14
`define OFS_RX_HOLD    8'h18
`define OFS_TGT_ADDR   8'h1c
`define OFS_TX_HOLD    8'h20
`define OFS_MODE_CTRL  8'h24
`define OFS_INT_VEC    8'h28
`define OFS_EXT_MODE   8'h2c
`define OFS_PRESCALE   8'h30

`define FLG_AL         0
`define FLG_NO_ACKNOWLEDGE_FLAG       1
`define FLG_REGISTERS_READY_FLAG       2
`define FLG_RRDY       3
`define FLG_XRDY       4
`define FLG_SCD        5
`define FLG_AAS        6
`define STS_AAS_BIT    9
`define STS_BUSY_BIT   12
`define FLAGS_RESET    7'h10

`define MODE_RUN_BIT   0
`define MODE_FREE_BIT  1
`define MODE_MST_BIT   2
`define MODE_RESET     16'h0000

`endif

// ---- common/i2c_ctrl_pkg.sv ----
// Types shared by the control layer
package i2c_ctrl_pkg;
  typedef logic [6:0] flagVec_t;
  typedef enum logic [2:0] {
    VEC_NONE = 3'h0,
    VEC_AL   = 3'h1,
    VEC_NO_ACKNOWLEDGE_FLAG = 3'h2,
    VEC_REGISTERS_READY_FLAG = 3'h3,
    VEC_RRDY = 3'h4,
    VEC_XRDY = 3'h5,
    VEC_SCD  = 3'h6,
    VEC_AAS  = 3'h7
  } vecCode_t;
endpackage

// ---- src/bus_cond_monitor.sv ----
// Line synchroniser and START/STOP detector for the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module bus_cond_monitor (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic startSeen,
  output var  logic stopSeen,
  output var  logic busBusy
);
  logic [1:0] sclMeta_q;
  logic [1:0] sdaMeta_q;
  logic       sclOld_q;
  logic       sdaOld_q;

  // Two stages before any logic looks at the lines
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sclOld_q  <= 1'b1;
      sdaOld_q  <= 1'b1;
    end else begin
      sclMeta_q <= {sclMeta_q[0], scl_i};
      sdaMeta_q <= {sdaMeta_q[0], sda_i};
      sclOld_q  <= sclMeta_q[1];
      sdaOld_q  <= sdaMeta_q[1];
    end
  end

  // Data edge while clock stays high marks a condition
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      startSeen <= 1'b0;
      stopSeen  <= 1'b0;
    end else begin
      startSeen <= sclOld_q & sclMeta_q[1] & sdaOld_q & ~sdaMeta_q[1];
      stopSeen  <= sclOld_q & sclMeta_q[1] & ~sdaOld_q & sdaMeta_q[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busBusy <= 1'b0;
    end else if (startSeen) begin
      busBusy <= 1'b1;
    end else if (stopSeen) begin
      busBusy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- src/i2c_ctrl_top.sv ----
// Reset, flag, vector, DMA and APB register control of a two-wire bus port
// What this block does
// - Run bit low: flags default, block disabled
// - While in software reset, release both pins
// - Hardware reset loads defaults, waits run bit
// - Reset clears errors, engine idles saving power
// - One dedicated interrupt output for all sources
// - Vector names event, read clears top flag
// - Pending flags after read: fresh interrupt
// - Flags always set; mask gates the interrupt
// - Arbitration lost or illegal condition sets flag
// - Master without acknowledge sets no-ack flag
// - Command complete sets registers-ready flag
// - Receive copy sets receive-ready flag
// - Transmit copy sets transmit-ready flag
// - STOP on bus sets stop-detected flag
// - Own or all-zero address sets slave flag
// - Receive copy issues receive DMA event
// - Transmit copy issues transmit DMA event
// - Suspend stops engine unless free-run set
// - Lost arbitration drops to slave receiver
// - Flags clear by writing one, zero ignored
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_regs.svh"
module i2c_ctrl_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sclOut,
  output var  logic        sclOe,
  output var  logic        sdaOut,
  output var  logic        sdaOe,
  input  wire logic        engSclLow,
  input  wire logic        engSdaLow,
  input  wire logic        engMidByte,
  input  wire logic        evArbLost,
  input  wire logic        evNoAck,
  input  wire logic        evCmdDone,
  input  wire logic        evRxCopy,
  input  wire logic [7:0]  rxByte,
  input  wire logic        evTxCopy,
  input  wire logic        evAddrByte,
  input  wire logic [7:0]  addrByte,
  input  wire logic        emuSuspend,
  output var  logic        irq,
  output var  logic        rxDmaReq,
  output var  logic        txDmaReq,
  output var  logic        engineEnable,
  output var  logic [15:0] modeCtrl,
  output var  logic [7:0]  txByte,
  output var  logic [9:0]  ownAddr,
  output var  logic [9:0]  targetAddr,
  output var  logic [15:0] sclLowDiv,
  output var  logic [15:0] sclHighDiv,
  output var  logic [15:0] byteCount,
  output var  logic [7:0]  prescale,
  output var  logic [1:0]  extMode
);
  i2c_ctrl_pkg::flagVec_t flag_q;
  i2c_ctrl_pkg::flagVec_t flag_d;
  i2c_ctrl_pkg::flagVec_t mask_q;
  i2c_ctrl_pkg::flagVec_t flagSet;
  i2c_ctrl_pkg::flagVec_t flagClr;
  i2c_ctrl_pkg::vecCode_t vecNow;
  logic [7:0]  rxHold_q;
  logic [31:0] rdMux;
  logic        runBit;
  logic        freeBit;
  logic        accessCyc;
  logic        commit;
  logic        wrOk;
  logic        vecRead;
  logic        startSeen;
  logic        stopSeen;
  logic        busBusy;
  logic        addrMatch;
  logic        illegalCond;

  // Highest-priority pending flag, lowest index first
  function automatic i2c_ctrl_pkg::vecCode_t topCode(
    input i2c_ctrl_pkg::flagVec_t pend);
    topCode = i2c_ctrl_pkg::VEC_NONE;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        topCode = i2c_ctrl_pkg::vecCode_t'(3'(i + 1));
      end
    end
  endfunction

  function automatic i2c_ctrl_pkg::flagVec_t codeBit(input logic [2:0] c);
    codeBit = '0;
    if (c != 3'h0) begin
      codeBit[c - 3'h1] = 1'b1;
    end
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `OFS_PRESCALE);
  endfunction

  bus_cond_monitor uMon (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .startSeen (startSeen),
    .stopSeen  (stopSeen),
    .busBusy   (busBusy)
  );

  assign runBit    = modeCtrl[`MODE_RUN_BIT];
  assign freeBit   = modeCtrl[`MODE_FREE_BIT];
  // Zero-wait decode would need a combinational prdata, so one extra cycle
  assign accessCyc = psel & penable & ~pready;
  assign commit    = psel & penable & pready;
  assign wrOk      = commit & pwrite & ~pslverr;
  assign vecRead   = commit & ~pwrite & (paddr == `OFS_INT_VEC);
  assign vecNow    = topCode(flag_q & mask_q);
  // 7-bit own address, read/write bit excluded; general call needs the whole byte zero
  assign addrMatch = (addrByte[7:1] == ownAddr[6:0]) || (addrByte == 8'h00);
  // Condition inside a byte cannot be legal
  assign illegalCond = (startSeen | stopSeen) & engMidByte;

  always_comb begin
    flagSet = '0;
    flagSet[`FLG_AL]   = evArbLost | illegalCond;
    flagSet[`FLG_NO_ACKNOWLEDGE_FLAG] = evNoAck & modeCtrl[`MODE_MST_BIT];
    flagSet[`FLG_REGISTERS_READY_FLAG] = evCmdDone;
    flagSet[`FLG_RRDY] = evRxCopy;
    flagSet[`FLG_XRDY] = evTxCopy;
    flagSet[`FLG_SCD]  = stopSeen;
    flagSet[`FLG_AAS]  = evAddrByte & addrMatch;
  end

  always_comb begin
    flagClr = '0;
    if (vecRead) begin
      flagClr = codeBit(prdata[2:0]);
    end
    if (wrOk && paddr == `OFS_INT_FLAGS) begin
      flagClr = flagClr | {pwdata[`STS_AAS_BIT], pwdata[5:0]};
    end
    flag_d = (flag_q & ~flagClr) | flagSet;
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !runBit) begin
      flag_q <= `FLAGS_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ownAddr    <= '0;
      mask_q     <= '0;
      sclLowDiv  <= '0;
      sclHighDiv <= '0;
      byteCount  <= '0;
      targetAddr <= '0;
      txByte     <= '0;
      extMode    <= '0;
      prescale   <= '0;
    end else if (wrOk) begin
      case (paddr)
        `OFS_OWN_ADDR: ownAddr    <= pwdata[9:0];
        `OFS_INT_MASK: mask_q     <= pwdata[6:0];
        `OFS_SCL_LOW:  sclLowDiv  <= pwdata[15:0];
        `OFS_SCL_HIGH: sclHighDiv <= pwdata[15:0];
        `OFS_BYTE_CNT: byteCount  <= pwdata[15:0];
        `OFS_TGT_ADDR: targetAddr <= pwdata[9:0];
        `OFS_TX_HOLD:  txByte     <= pwdata[7:0];
        `OFS_EXT_MODE: extMode    <= pwdata[1:0];
        `OFS_PRESCALE: prescale   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modeCtrl <= `MODE_RESET;
    end else begin
      if (wrOk && paddr == `OFS_MODE_CTRL) begin
        modeCtrl <= pwdata[15:0];
      end
      if (runBit && evArbLost) begin
        modeCtrl[`MODE_MST_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxHold_q <= '0;
    end else if (runBit && evRxCopy) begin
      rxHold_q <= rxByte;
    end
  end

  always_comb begin
    rdMux = '0;
    case (paddr)
      `OFS_OWN_ADDR:  rdMux[9:0]  = ownAddr;
      `OFS_INT_MASK:  rdMux[6:0]  = mask_q;
      `OFS_INT_FLAGS: begin
        rdMux[5:0]           = flag_q[5:0];
        rdMux[`STS_AAS_BIT]  = flag_q[`FLG_AAS];
        rdMux[`STS_BUSY_BIT] = busBusy;
      end
      `OFS_SCL_LOW:   rdMux[15:0] = sclLowDiv;
      `OFS_SCL_HIGH:  rdMux[15:0] = sclHighDiv;
      `OFS_BYTE_CNT:  rdMux[15:0] = byteCount;
      `OFS_RX_HOLD:   rdMux[7:0]  = rxHold_q;
      `OFS_TGT_ADDR:  rdMux[9:0]  = targetAddr;
      `OFS_TX_HOLD:   rdMux[7:0]  = txByte;
      `OFS_MODE_CTRL: rdMux[15:0] = modeCtrl;
      `OFS_INT_VEC:   rdMux[2:0]  = vecNow;
      `OFS_EXT_MODE:  rdMux[1:0]  = extMode;
      `OFS_PRESCALE:  rdMux[7:0]  = prescale;
      default:        rdMux       = '0;
    endcase
  end

  // Read data and error frozen in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= accessCyc;
      if (accessCyc) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= ~isMapped(paddr);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(flag_q & mask_q)) & ~vecRead;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxDmaReq <= 1'b0;
      txDmaReq <= 1'b0;
    end else begin
      rxDmaReq <= runBit & evRxCopy;
      txDmaReq <= runBit & evTxCopy;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      engineEnable <= 1'b0;
    end else begin
      engineEnable <= runBit & ~(emuSuspend & ~freeBit);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOe  <= runBit & engSclLow;
      sdaOe  <= runBit & engSdaLow;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  sequence seqVecRead2;
    vecRead && ($countones(flag_q & mask_q) > 1);
  endsequence

  sequence seqIrqBounce;
    !irq ##1 irq;
  endsequence

  AST_RUN_LOW_FLAGS: assert property (@(posedge clk_sys) disable iff (reset)
    !runBit |=> flag_q == `FLAGS_RESET) else $error("flags not at default");
  AST_PINS_RELEASED: assert property (@(posedge clk_sys) disable iff (reset)
    !runBit |=> !sclOe && !sdaOe) else $error("pin driven in reset");
  AST_ENGINE_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
    !runBit |=> !engineEnable) else $error("engine on in reset");
  AST_FRESH_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
    seqVecRead2 |=> seqIrqBounce) else $error("no fresh interrupt");
  AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
    !(|(flag_q & mask_q)) |=> !irq) else $error("irq without pending");
  AST_FLAG_UNMASKED: assert property (@(posedge clk_sys) disable iff (reset)
    runBit && evCmdDone ##1 runBit |-> flag_q[`FLG_REGISTERS_READY_FLAG])
    else $error("ready flag missed");
  AST_RX_DMA: assert property (@(posedge clk_sys) disable iff (reset)
    runBit && evRxCopy |=> rxDmaReq && rxHold_q == $past(rxByte))
    else $error("receive event missing");
  AST_TX_DMA: assert property (@(posedge clk_sys) disable iff (reset)
    runBit && evTxCopy |=> txDmaReq) else $error("transmit event missing");
  AST_ARB_LOSS: assert property (@(posedge clk_sys) disable iff (reset)
    runBit && evArbLost |=> !modeCtrl[`MODE_MST_BIT] && flag_q[`FLG_AL])
    else $error("arbitration loss not handled");
  AST_EMU_HALT: assert property (@(posedge clk_sys) disable iff (reset)
    emuSuspend && !freeBit |=> !engineEnable) else $error("runs in suspend");
  AST_STOP_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
    runBit && stopSeen ##1 runBit |-> flag_q[`FLG_SCD])
    else $error("stop not flagged");
endmodule
`default_nettype wire

// ---- sim/bus_peer.sv ----
// Far-side two-wire bus party: pull-ups, START, STOP and hang recovery
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  input  wire logic clk_sys,
  input  wire logic sclOe,
  input  wire logic sdaOe,
  output wire logic scl_i,
  output wire logic sda_i
);
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  // Pulled-up lines: low if any party pulls
  assign scl_i = !(sclOe | sclLow);
  assign sda_i = !(sdaOe | sdaLow);
  // Half of the 80 ns link period
  task automatic half();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic start_cond();
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b1;
    half();
  endtask
  task automatic stop_cond();
    sclLow <= 1'b1;
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b0;
    half();
    sdaLow <= 1'b0;
    half();
  endtask
  task automatic recover();
    sdaLow <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      sclLow <= 1'b1;
      half();
      sclLow <= 1'b0;
      half();
      if (sda_i === 1'b1) break;
    end
    start_cond();
  endtask
endmodule
`default_nettype wire

// ---- sim/test_i2c_ctrl_top.sv ----
// Self-checking bench of the reset, flag, vector and DMA control block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_regs.svh"
module test_i2c_ctrl_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, lastErr;
  logic        scl_i, sda_i, sclOut, sclOe, sdaOut, sdaOe;
  logic        engSclLow = 1'b0, engSdaLow = 1'b0, engMidByte = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [7:0]  rxByte = 8'h00, addrByte = 8'h00;
  logic        emuSuspend = 1'b0;
  logic        irq, rxDmaReq, txDmaReq, engineEnable;
  logic [15:0] modeCtrl, sclLowDiv, sclHighDiv, byteCount;
  logic [9:0]  ownAddr, targetAddr;
  logic [7:0]  txByte, prescale;
  logic [1:0]  extMode;
  int          miscompares = 0;
  int          total_checks = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  i2c_ctrl_top i_dut (.clk_sys(clk_sys), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
    .sda_i(sda_i), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .engSclLow(engSclLow), .engSdaLow(engSdaLow),
    .engMidByte(engMidByte), .evArbLost(ev[0]), .evNoAck(ev[1]),
    .evCmdDone(ev[2]), .evRxCopy(ev[3]), .rxByte(rxByte),
    .evTxCopy(ev[4]), .evAddrByte(ev[5]), .addrByte(addrByte),
    .emuSuspend(emuSuspend), .irq(irq), .rxDmaReq(rxDmaReq),
    .txDmaReq(txDmaReq), .engineEnable(engineEnable),
    .modeCtrl(modeCtrl), .txByte(txByte), .ownAddr(ownAddr),
    .targetAddr(targetAddr), .sclLowDiv(sclLowDiv),
    .sclHighDiv(sclHighDiv), .byteCount(byteCount), .prescale(prescale),
    .extMode(extMode));
  bus_peer i_peer (.clk_sys(clk_sys), .sclOe(sclOe), .sdaOe(sdaOe),
    .scl_i(scl_i), .sda_i(sda_i));
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
      miscompares++;
    end
  endtask
  // Setup, access, hold until pready sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      $display("Error %0t: no pready", $time);
      miscompares++;
      finish_test();
    end
  endtask
  // One-edge event; outputs read where they stand
  task automatic pulse(input int b);
    @(posedge clk_sys);
    ev[b] <= 1'b1;
    @(posedge clk_sys);
    ev[b] <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_reset();
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h10, "flags reset");
    apb(0, `OFS_MODE_CTRL, 0);
    chk(rdv, 32'h0, "mode reset");
    chk({sclOe, sdaOe, engineEnable}, 0, "idle pins");
    apb(0, 8'h34, 0);
    chk(rdv, 0, "unmapped data");
    chk(lastErr, 1, "unmapped");
    apb(1, `OFS_INT_VEC, 32'h7);
    chk(lastErr, 0, "ro write");
  endtask
  task automatic t_regs();
    apb(1, `OFS_SCL_LOW, 32'h1234);
    apb(1, `OFS_SCL_HIGH, 32'h5678);
    apb(1, `OFS_BYTE_CNT, 32'h9abc);
    apb(1, `OFS_TGT_ADDR, 32'h3ff);
    apb(1, `OFS_TX_HOLD, 32'h1c3);
    apb(1, `OFS_EXT_MODE, 32'h7);
    apb(1, `OFS_PRESCALE, 32'h1ee);
    @(posedge clk_sys);
    chk({sclLowDiv, sclHighDiv}, 32'h1234_5678, "dividers");
    chk({4'h0, byteCount, targetAddr, extMode}, 32'h09ab_cfff, "count");
    chk({16'h0, txByte, prescale}, 32'h0000_c3ee, "tx and prescale");
    apb(0, `OFS_BYTE_CNT, 0);
    chk(rdv, 32'h9abc, "count readback");
    apb(0, `OFS_TGT_ADDR, 0);
    chk(rdv, 32'h3ff, "target readback");
  endtask
  task automatic t_swreset();
    pulse(3);
    chk(rxDmaReq, 0, "dma while off");
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h10, "events ignored");
    apb(1, `OFS_MODE_CTRL, 32'h1);
    pulse(0);
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h11, "al set");
    apb(1, `OFS_MODE_CTRL, 32'h0);
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h10, "al cleared");
  endtask
  task automatic t_events();
    // Configure with run low first
    apb(1, `OFS_OWN_ADDR, 32'h2a);
    apb(1, `OFS_MODE_CTRL, 32'h5);
    chk({22'h0, ownAddr}, 32'h2a, "own address");
    pulse(1);
    pulse(2);
    rxByte <= 8'ha5;
    pulse(3);
    chk(rxDmaReq, 1, "rx dma");
    pulse(4);
    chk(txDmaReq, 1, "tx dma");
    addrByte <= 8'h54;
    pulse(5);
    i_peer.start_cond();
    i_peer.stop_cond();
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h23e, "flags");
    apb(0, `OFS_RX_HOLD, 0);
    chk(rdv, 32'ha5, "rx hold");
    pulse(0);
    chk(modeCtrl, 16'h1, "master dropped");
    apb(1, `OFS_INT_FLAGS, 0);
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h23f, "w0 kept");
    apb(1, `OFS_INT_FLAGS, 32'h23f);
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv, 32'h0, "w1 clear");
  endtask
  task automatic t_irq();
    // Master bit was dropped, so ready event instead of no-ack
    addrByte <= 8'h00;
    pulse(3);
    pulse(2);
    repeat (3) @(posedge clk_sys);
    chk(irq, 0, "masked");
    apb(1, `OFS_INT_MASK, 32'h7f);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1, "unmasked");
    apb(0, `OFS_INT_VEC, 0);
    chk(rdv, 32'h3, "vec registers_ready_flag");
    pulse(5);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1, "fresh irq");
    apb(0, `OFS_INT_VEC, 0);
    chk(rdv, 32'h4, "vec rrdy");
    apb(0, `OFS_INT_VEC, 0);
    chk(rdv, 32'h7, "vec zero addr");
    repeat (3) @(posedge clk_sys);
    chk(irq, 0, "irq low");
    apb(0, `OFS_INT_VEC, 0);
    chk(rdv, 32'h0, "vec none");
  endtask
  task automatic t_emu();
    emuSuspend <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(engineEnable, 0, "suspend stops");
    // Run dropped first, then run and free bits set in one write
    apb(1, `OFS_MODE_CTRL, 32'h0);
    apb(1, `OFS_MODE_CTRL, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk(engineEnable, 1, "free runs");
    emuSuspend <= 1'b0;
  endtask
  task automatic t_pins();
    engSclLow <= 1'b1;
    engSdaLow <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({sclOe, sdaOe, scl_i, sclOut, sdaOut}, 5'b11000, "pins driven");
    // Far side idle, so no transfer is cut
    apb(1, `OFS_MODE_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk({sclOe, sdaOe, scl_i, sda_i}, 4'b0011, "released");
    engSclLow <= 1'b0;
    engSdaLow <= 1'b0;
  endtask
  task automatic t_illegal();
    apb(1, `OFS_MODE_CTRL, 32'h1);
    engMidByte <= 1'b1;
    i_peer.start_cond();
    engMidByte <= 1'b0;
    apb(0, `OFS_INT_FLAGS, 0);
    chk(rdv[0], 1, "illegal start");
    chk(rdv[12], 1, "bus busy");
    i_peer.recover();
    i_peer.stop_cond();
    chk(sda_i, 1, "bus free");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_swreset();
    t_events();
    t_irq();
    t_emu();
    t_pins();
    t_illegal();
    finish_test();
  end
endmodule
`default_nettype wire
